// File: core/bmc_basic_control.sv
// basic mode control register, low control bits, with Avalon-MM slave
// assumes MII tx_en and pcs_col come from logic on mclk; pins and straps are asynchronous
`timescale 1ns/1ps

// Summary of operation
// - power-down stops PHY, registers stay alive
// - pin low ORs in and sets bit
// - isolate bit cuts MII, management stays
// - restart bit reads one until initiated
// - restart write ignored when negotiation off
// - writing zero leaves running negotiation alone
// - duplex bit forces duplex, strap reset
// - collision test raises COL after TX_EN
// - COL falls within four bits
// - bits six to zero read zero
// - negotiation on overrides speed, duplex bits
module bmc_basic_control (
  input wire logic mclk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [bmc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // pins and straps
  input wire logic power_down_interrupt_pin_n,
  input wire logic [2:0] strap_in,
  // auto-negotiation engine
  input wire logic an_restart_ack,
  input wire logic an_full_duplex,
  input wire logic an_speed_100,
  // MII towards the MAC
  input wire logic tx_en,
  input wire logic pcs_col,
  output logic col,
  output logic mii_out_en,
  // controls to the PHY functions
  output bmc_pkg::bmc_ctrl_s phy_ctrl,
  output logic phy_enable,
  output logic an_restart_req
);
  import bmc_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic pd_pin_n;
  bmc_strap_s strap;

  bmc_sync #(
    .WIDTH(1),
    .RST_VAL(1'h1)
  ) u_pd_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d(power_down_interrupt_pin_n),
    .q(pd_pin_n)
  );

  bmc_sync #(
    .WIDTH(3),
    .RST_VAL(3'h0)
  ) u_strap_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d(strap_in),
    .q(strap)
  );

  // ****************************************
  // strap capture after reset release
  // ****************************************
  logic [1:0] strap_cnt;
  logic strap_load;

  assign strap_load = (strap_cnt == STRAP_LOAD_CYC);

  // count off the synchroniser delay, then load once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // ****************************************
  // Avalon-MM handshake
  // ****************************************
  bmc_bus_e bus_state;
  logic req;
  logic hit;
  logic wr_go;
  logic wr_lo;
  logic wr_hi;

  assign req = avs_read | avs_write;
  assign hit = (avs_address == BASIC_MODE_CONTROL_OFS);
  // request completes in the second cycle it is held
  assign avs_waitrequest = req & (bus_state != BUS_ANSWER);
  assign wr_go = avs_write & (bus_state == BUS_ANSWER) & hit;
  // lanes 2 and 3 carry no register bits and are ignored
  assign wr_lo = wr_go & avs_byteenable[0];
  assign wr_hi = wr_go & avs_byteenable[1];

  // one wait cycle per request
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (req) begin
            bus_state <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // register bits
  // ****************************************
  logic speed_sel;
  logic an_enable;
  logic power_down;
  logic isolate;
  logic an_restart;
  logic duplex_sel;
  logic col_test;

  // speed select, loaded from strap, used only while negotiation is off
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      speed_sel <= SPEED_RST;
    end else if (strap_load) begin
      speed_sel <= strap.speed_100;
    end else if (wr_hi) begin
      speed_sel <= avs_writedata[SPEED_BIT];
    end
  end

  // negotiation enable, loaded from strap; gates restart and forced modes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      an_enable <= AN_ENABLE_RST;
    end else if (strap_load) begin
      an_enable <= strap.an_enable;
    end else if (wr_hi) begin
      an_enable <= avs_writedata[AN_ENABLE_BIT];
    end
  end

  // power-down: pin assertion sets the bit and wins over a write of zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_down <= POWER_DOWN_RST;
    end else if (!pd_pin_n) begin
      power_down <= 1'h1;
    end else if (wr_hi) begin
      power_down <= avs_writedata[POWER_DOWN_BIT];
    end
  end

  // isolate from MII
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      isolate <= ISOLATE_RST;
    end else if (wr_hi) begin
      isolate <= avs_writedata[ISOLATE_BIT];
    end
  end

  // restart request: set by a one written while negotiation is on,
  // cleared when the engine takes it or negotiation is off; a written zero changes nothing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      an_restart <= AN_RESTART_RST;
    end else if (wr_hi && avs_writedata[AN_RESTART_BIT] && an_enable) begin
      an_restart <= 1'h1;
    end else if (an_restart_ack || !an_enable) begin
      an_restart <= 1'h0;
    end
  end

  // duplex select, loaded from strap
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      duplex_sel <= DUPLEX_RST;
    end else if (strap_load) begin
      duplex_sel <= strap.full_duplex;
    end else if (wr_hi) begin
      duplex_sel <= avs_writedata[DUPLEX_BIT];
    end
  end

  // collision test enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      col_test <= COL_TEST_RST;
    end else if (wr_lo) begin
      col_test <= avs_writedata[COL_TEST_BIT];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [15:0] reg_view;

  // low seven bits are never stored and always read zero
  always_comb begin
    reg_view = 16'h0000;
    reg_view[SPEED_BIT] = speed_sel;
    reg_view[AN_ENABLE_BIT] = an_enable;
    reg_view[POWER_DOWN_BIT] = power_down;
    reg_view[ISOLATE_BIT] = isolate;
    reg_view[AN_RESTART_BIT] = an_restart;
    reg_view[DUPLEX_BIT] = duplex_sel;
    reg_view[COL_TEST_BIT] = col_test;
  end

  // read data loaded in the wait cycle, stands at completion
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && bus_state == BUS_IDLE) begin
      avs_readdata <= (avs_read && hit) ? {16'h0000, reg_view} : 32'h0000_0000;
    end
  end

  // response code loaded with the data; unmapped addresses answer an error
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      avs_response <= RESP_OKAY;
    end else if (req && bus_state == BUS_IDLE) begin
      avs_response <= hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // PHY controls
  // ****************************************
  logic pd_eff;

  // power-down is the bit or the pin
  assign pd_eff = power_down | ~pd_pin_n;

  // only the register block keeps running while powered down
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phy_enable <= 1'h0;
    end else begin
      phy_enable <= ~pd_eff;
    end
  end

  // mode controls handed to the PHY functions, one cycle behind the bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phy_ctrl <= '0;
    end else begin
      phy_ctrl.power_down <= pd_eff;
      phy_ctrl.isolate <= isolate;
      phy_ctrl.an_enable <= an_enable;
      // negotiated result overrides the forced bits while enabled
      phy_ctrl.speed_100 <= an_enable ? an_speed_100 : speed_sel;
      phy_ctrl.full_duplex <= an_enable ? an_full_duplex : duplex_sel;
    end
  end

  // restart request level toward the negotiation engine
  assign an_restart_req = an_restart & ~pd_eff;

  // ****************************************
  // MII collision and isolation
  // ****************************************
  // MAC-facing outputs are released while isolated or powered down
  assign mii_out_en = ~isolate & ~pd_eff;

  // collision follows tx_en with one cycle of delay in test mode,
  // well inside both the rise and the fall limits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      col <= 1'h0;
    end else if (isolate || pd_eff) begin
      col <= 1'h0;
    end else if (col_test) begin
      col <= tx_en;
    end else begin
      col <= pcs_col;
    end
  end

endmodule : bmc_basic_control

// File: core/bmc_pkg.sv
// basic mode control package: register map, field positions, reset values, timing
// assumes a 50 MHz system clock and a 32-bit Avalon-MM register port
package bmc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] BASIC_MODE_CONTROL_OFS = 4'h0;

  // field positions inside basic_mode_control
  localparam int unsigned SPEED_BIT = 13;
  localparam int unsigned AN_ENABLE_BIT = 12;
  localparam int unsigned POWER_DOWN_BIT = 11;
  localparam int unsigned ISOLATE_BIT = 10;
  localparam int unsigned AN_RESTART_BIT = 9;
  localparam int unsigned DUPLEX_BIT = 8;
  localparam int unsigned COL_TEST_BIT = 7;

  // values after reset for the plain read/write bits
  localparam logic POWER_DOWN_RST = 1'h0;
  localparam logic ISOLATE_RST = 1'h0;
  localparam logic AN_RESTART_RST = 1'h0;
  localparam logic COL_TEST_RST = 1'h0;
  // strap-loaded bits hold these until the straps are captured
  localparam logic DUPLEX_RST = 1'h0;
  localparam logic SPEED_RST = 1'h0;
  localparam logic AN_ENABLE_RST = 1'h0;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BIT_TIME_NS = 10; // shortest bit time, 100 Mb/s
  localparam int unsigned COL_ASSERT_BITS = 512;
  localparam int unsigned COL_DEASSERT_BITS = 4;
  localparam int unsigned COL_ASSERT_MAX_CYC =
    (COL_ASSERT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int unsigned COL_DEASSERT_MAX_CYC =
    ((COL_DEASSERT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS) < 1 ? 1 :
    ((COL_DEASSERT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS);
  // cycles after reset release until synchronised straps are loaded
  localparam logic [1:0] STRAP_LOAD_CYC = 2'h2;

  // ****************************************
  // types
  // ****************************************
  // mode controls handed to the PHY functions
  typedef struct packed {
    logic power_down;
    logic isolate;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
  } bmc_ctrl_s;

  // straps sampled at reset
  typedef struct packed {
    logic an_enable;
    logic speed_100;
    logic full_duplex;
  } bmc_strap_s;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bmc_bus_e;

endpackage : bmc_pkg

// File: core/bmc_sync.sv
// two-flop synchroniser for levels entering the mclk domain
// assumes each bit is a slow level; no bit relation is kept across the bus
`timescale 1ns/1ps
module bmc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : bmc_sync

// File: bench/bmc_basic_control_asserts.sv
// checker for the basic mode control block, watching its ports only
// assumes one mclk domain and nrst active low
`timescale 1ns/1ps
module bmc_basic_control_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic power_down_interrupt_pin_n,
  input wire logic an_restart_ack,
  input wire logic an_full_duplex,
  input wire logic tx_en,
  input wire logic pcs_col,
  input wire logic col,
  input wire logic mii_out_en,
  input wire bmc_pkg::bmc_ctrl_s phy_ctrl,
  input wire logic phy_enable,
  input wire logic an_restart_req
);
  import bmc_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // one wait cycle per request
  wait_once_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("wait cycle count wrong");
  rsvd_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[6:0] == 7'h00
    && avs_readdata[31:16] == 16'h0000) else $error("reserved bits not zero");
  pd_stop_a: assert property (phy_ctrl.power_down [*2] |-> !phy_enable)
    else $error("phy runs in power down");
  pin_sets_a: assert property (!power_down_interrupt_pin_n [*3] |-> ##[0:3]
    phy_ctrl.power_down) else $error("pin did not power down");
  iso_cut_a: assert property ($past(mii_out_en) == !(phy_ctrl.isolate ||
    phy_ctrl.power_down)) else $error("mii enable wrong");
  pin_stop_a: assert property (!power_down_interrupt_pin_n [*4] |-> !phy_enable)
    else $error("phy runs with pin low");
  col_iso_a: assert property (!mii_out_en [*2] |-> !col)
    else $error("col while isolated");
  col_fall_a: assert property (!tx_en && !pcs_col |=> !col)
    else $error("col did not fall");
  ack_clear_a: assert property (an_restart_req && an_restart_ack |=> !an_restart_req)
    else $error("restart not cleared");
  rst_needs_an_a: assert property ($rose(an_restart_req) |-> phy_ctrl.an_enable)
    else $error("restart without negotiation");
  an_follow_a: assert property (phy_ctrl.an_enable [*2] ##0 $stable(an_full_duplex) |->
    phy_ctrl.full_duplex == an_full_duplex) else $error("duplex not from engine");
  // main scenarios seen
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(col));
  cover property ($fell(an_restart_req));
endmodule : bmc_basic_control_asserts

// File: bench/bmc_an_partner.sv
// negotiation engine stand-in that acknowledges a restart request
// assumes the request is a level on mclk held until acknowledged
`timescale 1ns/1ps
module bmc_an_partner #(
  parameter int unsigned DLY = 6
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic an_restart_req,
  output logic an_restart_ack
);
  logic [7:0] cnt;
  // count request cycles, pulse the ack once, slow enough to read the bit set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
      an_restart_ack <= 1'h0;
    end else begin
      an_restart_ack <= an_restart_req && (cnt == 8'(DLY));
      cnt <= an_restart_req ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule : bmc_an_partner

// File: bench/testbench.sv
// self-checking bench for the basic mode control block
// assumes the checker and the negotiation partner files are compiled first
`timescale 1ns/1ps
module testbench;
  import bmc_pkg::*;
  logic mclk = 1'h0, nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic pin_n = 1'h1, an_fd = 1'h0, tx_en = 1'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0] avs_response, rsp;
  logic avs_waitrequest, col, mii_out_en, phy_enable, an_restart_req, an_restart_ack;
  bmc_ctrl_s phy_ctrl;
  int miscompares = 0, compares = 0;
  always #10 mclk = ~mclk;
  bmc_basic_control dut_u (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest,
    .power_down_interrupt_pin_n(pin_n), .strap_in(3'h5), .an_restart_ack,
    .an_full_duplex(an_fd), .an_speed_100(an_fd), .tx_en, .pcs_col(1'h0), .col,
    .mii_out_en, .phy_ctrl, .phy_enable, .an_restart_req);
  bmc_an_partner #(.DLY(6)) an_u (.mclk, .nrst, .an_restart_req, .an_restart_ack);
  // ****************************************
  // tasks
  // ****************************************
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task cmp_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t reg %h exp %h", $time, g, e);
    end
  endtask : cmp_reg
  task cmp_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t flag %b exp %b", $time, g, e);
    end
  endtask : cmp_bit
  // one Avalon cycle, held until waitrequest is sampled low, then one idle edge
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge mclk);
    if (n >= 20) begin
      miscompares++;
      finish_test;
    end
  endtask : bus
  task rd_exp(input logic [31:0] e);
    bus(1'h0, 4'h0, 16'h0000, 4'hF);
    cmp_reg(rd, e);
  endtask : rd_exp
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    repeat (4) @(posedge mclk);
    rd_exp(32'h1100);
    bus(1'h1, 4'h0, 16'hFFFF, 4'h1);
    rd_exp(32'h1180);
    bus(1'h1, 4'h4, 16'hFFFF, 4'hF);
    bus(1'h0, 4'h4, 16'h0000, 4'hF);
    cmp_reg({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd_exp(32'h1180);
    bus(1'h1, 4'h0, 16'hFFFF, 4'hF);
    rd_exp(32'h3F80);
    cmp_bit(mii_out_en, 1'h0);
    cmp_bit(phy_enable, 1'h0);
    bus(1'h1, 4'h0, 16'h1000, 4'hF);
    rd_exp(32'h1200);
    cmp_bit(phy_enable, 1'h1);
    repeat (12) @(posedge mclk);
    rd_exp(32'h1000);
    bus(1'h1, 4'h0, 16'h0000, 4'hF);
    bus(1'h1, 4'h0, 16'h0300, 4'hF);
    rd_exp(32'h0100);
    cmp_bit(phy_ctrl.full_duplex, 1'h1);
    bus(1'h1, 4'h0, 16'h1000, 4'hF);
    an_fd <= 1'h1;
    repeat (3) @(posedge mclk);
    cmp_bit(phy_ctrl.full_duplex, 1'h1);
    cmp_bit(phy_ctrl.speed_100, 1'h1);
    bus(1'h1, 4'h0, 16'h0080, 4'hF);
    tx_en <= 1'h1;
    repeat (2) @(posedge mclk);
    cmp_bit(col, 1'h1);
    cmp_bit(phy_ctrl.speed_100, 1'h0);
    tx_en <= 1'h0;
    repeat (2) @(posedge mclk);
    cmp_bit(col, 1'h0);
    bus(1'h1, 4'h0, 16'h0480, 4'hF);
    tx_en <= 1'h1;
    repeat (2) @(posedge mclk);
    cmp_bit(col, 1'h0);
    tx_en <= 1'h0;
    bus(1'h1, 4'h0, 16'h0000, 4'hF);
    pin_n <= 1'h0;
    repeat (6) @(posedge mclk);
    rd_exp(32'h0800);
    cmp_bit(phy_enable, 1'h0);
    pin_n <= 1'h1;
    repeat (3) @(posedge mclk);
    bus(1'h1, 4'h0, 16'h0000, 4'hF);
    rd_exp(32'h0000);
    finish_test;
  end
endmodule : testbench
bind bmc_basic_control bmc_basic_control_asserts chk_u (.mclk, .nrst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .power_down_interrupt_pin_n, .an_restart_ack,
  .an_full_duplex, .tx_en, .pcs_col, .col, .mii_out_en, .phy_ctrl, .phy_enable,
  .an_restart_req);
